// ---- verilog/pfp_pkg.sv ----
package pfp_pkg;
    localparam int          DATA_W       = 8;
    localparam int          FIFO_W       = DATA_W + 2;
    localparam int          FIFO_DEPTH   = 4;
    localparam int          FIFO_CNT_W   = $clog2(FIFO_DEPTH + 1);
    localparam int          HEAD_BYTES   = 256;
    localparam int          OFF_W        = 16;
    localparam int          TOD_W        = 96;
    localparam int          REG_AW       = 8;
    localparam int          REG_DW       = 32;

    // register byte addresses
    localparam logic [7:0]  REG_PATH_SKEW_DELAY_VALUE = 8'h00;
    localparam logic [7:0]  REG_CTRL                  = 8'h04;
    localparam logic [7:0]  REG_STATUS                = 8'h08;

    // values after reset
    localparam logic [31:0] SKEW_RST     = 32'h0000_0000;
    localparam logic        ONE_STEP_RST = 1'b0;

    // field positions and step counts
    localparam int          CTRL_ONE_STEP_BIT = 0;
    localparam int          STAT_BUSY_BIT     = 0;
    localparam int          STAT_CNT_LSB      = 16;
    localparam logic [3:0]  CF_LAST      = 4'h7;
    localparam logic [3:0]  TS_HI_BYTES  = 4'hA;
    localparam logic [3:0]  TS_LAST_96   = 4'hB;
    localparam logic [3:0]  TS_LAST_64   = 4'h7;
    localparam logic [3:0]  TS_SKIP_64   = 4'h2;
    localparam logic        FMT_96       = 1'b0;
    localparam logic        FMT_64       = 1'b1;
    localparam logic [31:0] NS_PER_SEC   = 32'h3B9A_CA00;

    typedef enum logic [2:0] {S_FILL, S_CF, S_TS, S_CK, S_DRAIN, S_PASS} pfp_state_e;

    typedef struct packed {
        pfp_state_e    st;
        logic [8:0]    idx;
        logic [8:0]    len;
        logic          head_eop;
        logic [3:0]    k;
        logic [95:0]   ts;
        logic [7:0]    a_ts;
        logic [7:0]    a_cf;
        logic [7:0]    a_ck;
        logic          do_ts;
        logic          fmt;
        logic          do_cf;
        logic          do_zero;
        logic          do_fix;
        logic [63:0]   add;
        logic          carry;
        logic [15:0]   acc;
        logic [15:0]   cknew;
        logic [31:0]   path_skew_delay_value;
        logic          one_step;
        logic [15:0]   pkt_cnt;
        logic [31:0]   rdata;
        logic          in_ready;
        logic          out_valid;
        logic          out_sop;
        logic          out_eop;
        logic [7:0]    out_data;
    } pfp_state_s;
endpackage

// ---- verilog/pfp_fifo_if.sv ----
`timescale 1ns/1ps
interface pfp_fifo_if #(parameter int W = 10, parameter int CW = 3);
    logic          wr_valid;
    logic          wr_ready;
    logic [W-1:0]  wr_data;
    logic          rd_valid;
    logic          rd_ready;
    logic [W-1:0]  rd_data;
    logic [CW-1:0] count;

    modport fifo (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data, count);
    modport user (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data, count);
endinterface

// ---- verilog/pfp_fifo.sv ----
`timescale 1ns/1ps
module pfp_fifo #(
    parameter int W     = 10,
    parameter int DEPTH = 4,
    parameter int CW    = $clog2(DEPTH + 1)
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    pfp_fifo_if.fifo f
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wp;
        logic [PW-1:0]           rp;
        logic [CW-1:0]           cnt;
    } pfp_fifo_s;

    pfp_fifo_s s_q;
    pfp_fifo_s s_d;
    logic      push;
    logic      pop;

    assign f.wr_ready = (s_q.cnt != CW'(DEPTH));
    assign f.rd_valid = (s_q.cnt != '0);
    assign f.rd_data  = s_q.mem[s_q.rp];
    assign f.count    = s_q.cnt;
    assign push       = f.wr_valid && f.wr_ready;
    assign pop        = f.rd_valid && f.rd_ready;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wp] = f.wr_data;
            s_d.wp = (s_q.wp == PW'(DEPTH - 1)) ? '0 : PW'(s_q.wp + 1'b1);
        end
        if (pop) begin
            s_d.rp = (s_q.rp == PW'(DEPTH - 1)) ? '0 : PW'(s_q.rp + 1'b1);
        end
        s_d.cnt = CW'(s_q.cnt + CW'(push) - CW'(pop));
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

// ---- verilog/pfp_rst_sync.sv ----
`timescale 1ns/1ps
module pfp_rst_sync (
    input  wire logic clk_i,
    input  wire logic resetn_i,
    output logic      rst_n_o
);
    typedef struct packed {
        logic first;
        logic second;
    } pfp_rst_s;

    pfp_rst_s s_q;
    pfp_rst_s s_d;

    always_comb begin
        s_d.first  = 1'b1;
        s_d.second = s_q.first;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rst_n_o = s_q.second;
endmodule

// ---- verilog/pfp_field_patcher.sv ----
`timescale 1ns/1ps
module pfp_field_patcher (
    input  wire logic                          clk_i,
    input  wire logic                          resetn_i,
    input  wire logic [pfp_pkg::REG_AW-1:0]    reg_addr_i,
    input  wire logic [pfp_pkg::REG_DW-1:0]    reg_wdata_i,
    input  wire logic                          reg_wr_i,
    input  wire logic                          reg_rd_i,
    output logic      [pfp_pkg::REG_DW-1:0]    reg_rdata_o,
    input  wire logic                          in_valid_i,
    output logic                               in_ready_o,
    input  wire logic [pfp_pkg::DATA_W-1:0]    in_data_i,
    input  wire logic                          in_sop_i,
    input  wire logic                          in_eop_i,
    input  wire logic                          ts_insert_i,
    input  wire logic                          ts_format_i,
    input  wire logic                          resid_update_i,
    input  wire logic                          skew_update_i,
    input  wire logic                          zero_cksum_i,
    input  wire logic                          fix_cksum_i,
    input  wire logic [pfp_pkg::OFF_W-1:0]     off_ts_i,
    input  wire logic [pfp_pkg::OFF_W-1:0]     off_cf_i,
    input  wire logic [pfp_pkg::OFF_W-1:0]     off_zero_i,
    input  wire logic [pfp_pkg::OFF_W-1:0]     off_fix_i,
    input  wire logic [pfp_pkg::TOD_W-1:0]     tod_i,
    input  wire logic [pfp_pkg::TOD_W-1:0]     ingress_i,
    output logic                               out_valid_o,
    input  wire logic                          out_ready_i,
    output logic      [pfp_pkg::DATA_W-1:0]    out_data_o,
    output logic                               out_sop_o,
    output logic                               out_eop_o
);
    import pfp_pkg::*;

    pfp_state_s            s_q;
    pfp_state_s            s_d;
    logic                  rst_n;
    logic [7:0]            head_mem [HEAD_BYTES];
    logic                  we;
    logic [7:0]            wa;
    logic [7:0]            wd;
    logic [7:0]            old_b;
    logic [8:0]            sum9;
    logic [3:0]            j;
    logic [95:0]           ts_sh;
    logic [15:0]           ck_old;
    logic [15:0]           ck_fix;
    logic [31:0]           resid_ns;
    logic [FIFO_CNT_W-1:0] cnt_next;
    logic                  accept;
    logic                  push;
    logic                  pop;
    logic                  last;

    pfp_fifo_if #(.W(FIFO_W), .CW(FIFO_CNT_W)) fq ();

    pfp_rst_sync u_rst (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .rst_n_o  (rst_n)
    );

    pfp_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH), .CW(FIFO_CNT_W)) u_fifo (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .f       (fq)
    );

    function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[15:0] + {15'h0000, s[16]};
    endfunction

    // ones-complement delta: add new byte, subtract old byte at its lane
    function automatic logic [15:0] oc_swap(input logic [15:0] acc, input logic [7:0] a,
                                            input logic [7:0] o, input logic [7:0] n);
        logic [15:0] nw;
        logic [15:0] ow;
        nw = a[0] ? {8'h00, n} : {n, 8'h00};
        ow = a[0] ? {8'hFF, ~o} : {~o, 8'hFF};
        return oc_add(oc_add(acc, nw), ow);
    endfunction

    assign accept   = in_valid_i && s_q.in_ready;
    assign push     = fq.wr_valid && fq.wr_ready;
    assign pop      = fq.rd_valid && fq.rd_ready;
    assign fq.rd_ready = !s_q.out_valid || out_ready_i;
    assign old_b    = head_mem[wa];
    assign sum9     = {1'b0, old_b} + {1'b0, s_q.add[{s_q.k[2:0], 3'b000} +: 8]}
                    + {8'h00, s_q.carry};
    assign j        = s_q.k + ((s_q.fmt == FMT_64) ? TS_SKIP_64 : 4'h0);
    assign ts_sh    = s_q.ts << {j, 3'b000};
    assign ck_old   = {head_mem[s_q.a_ck], head_mem[8'(s_q.a_ck + 8'h01)]};
    assign ck_fix   = ~oc_add(~ck_old, s_q.acc);
    assign resid_ns = (tod_i[47:16] >= ingress_i[47:16])
                    ? tod_i[47:16] - ingress_i[47:16]
                    : tod_i[47:16] + NS_PER_SEC - ingress_i[47:16];
    assign cnt_next = FIFO_CNT_W'(fq.count + FIFO_CNT_W'(push) - FIFO_CNT_W'(pop));
    assign last     = (s_q.idx == 9'(s_q.len - 9'h001));

    always_comb begin
        s_d         = s_q;
        we          = 1'b0;
        wa          = 8'h00;
        wd          = 8'h00;
        fq.wr_valid = 1'b0;
        fq.wr_data  = '0;
        unique case (s_q.st)
            S_FILL: begin
                if (accept) begin
                    // frame byte zero at start of packet
                    wa = in_sop_i ? 8'h00 : s_q.idx[7:0];
                    we = 1'b1;
                    wd = in_data_i;
                    s_d.idx = {1'b0, wa} + 9'h001;
                    if (in_sop_i) begin
                        s_d.ts      = tod_i;
                        s_d.fmt     = ts_format_i;
                        s_d.do_ts   = ts_insert_i;
                        s_d.do_cf   = resid_update_i || skew_update_i;
                        s_d.a_ts    = off_ts_i[7:0];
                        s_d.a_cf    = off_cf_i[7:0];
                        s_d.do_zero = zero_cksum_i && s_q.one_step;
                        s_d.do_fix  = fix_cksum_i && !zero_cksum_i && s_q.one_step;
                        s_d.a_ck    = zero_cksum_i ? off_zero_i[7:0] : off_fix_i[7:0];
                        s_d.add     = {16'h0000,
                                       (resid_update_i ? resid_ns : 32'h0000_0000)
                                       + (skew_update_i ? s_q.path_skew_delay_value
                                                        : 32'h0000_0000),
                                       16'h0000};
                        s_d.carry   = 1'b0;
                        s_d.acc     = 16'h0000;
                    end
                    if (in_eop_i || wa == 8'hFF) begin
                        s_d.len      = s_d.idx;
                        s_d.head_eop = in_eop_i;
                        s_d.idx      = 9'h000;
                        s_d.k        = 4'h0;
                        s_d.st       = s_d.do_cf ? S_CF : s_d.do_ts ? S_TS
                                     : (s_d.do_zero || s_d.do_fix) ? S_CK : S_DRAIN;
                    end
                end
            end
            S_CF: begin
                // correction field at correction offset, lsb first
                wa = 8'(s_q.a_cf + 8'(CF_LAST - s_q.k));
                we = 1'b1;
                wd = sum9[7:0];
                s_d.carry = sum9[8];
                // lane parity counts from the checksum offset, not from byte zero
                s_d.acc = oc_swap(s_q.acc, wa ^ s_q.a_ck, old_b, wd);
                if (s_q.k == CF_LAST) begin
                    s_d.k  = 4'h0;
                    s_d.st = s_q.do_ts ? S_TS : (s_q.do_zero || s_q.do_fix) ? S_CK : S_DRAIN;
                end else begin
                    s_d.k = s_q.k + 4'h1;
                end
            end
            S_TS: begin
                // 96-bit format: high ten bytes then low two bytes; 64-bit format: the eight bytes below the top two
                wa = (s_q.fmt == FMT_96 && s_q.k >= TS_HI_BYTES)
                   ? 8'(s_q.a_cf + 8'(s_q.k - TS_HI_BYTES))
                   : 8'(s_q.a_ts + 8'(s_q.k));
                we = 1'b1;
                wd = ts_sh[95:88];
                s_d.acc = oc_swap(s_q.acc, wa ^ s_q.a_ck, old_b, wd);
                if (s_q.k == ((s_q.fmt == FMT_64) ? TS_LAST_64 : TS_LAST_96)) begin
                    s_d.k  = 4'h0;
                    s_d.st = (s_q.do_zero || s_q.do_fix) ? S_CK : S_DRAIN;
                end else begin
                    s_d.k = s_q.k + 4'h1;
                end
            end
            S_CK: begin
                we = 1'b1;
                if (s_q.k == 4'h0) begin
                    s_d.cknew = s_q.do_zero ? 16'h0000
                              : (ck_fix == 16'h0000) ? 16'hFFFF : ck_fix;
                    wa = s_q.a_ck;
                    wd = s_d.cknew[15:8];
                    s_d.k = 4'h1;
                end else begin
                    wa = 8'(s_q.a_ck + 8'h01);
                    wd = s_q.cknew[7:0];
                    s_d.k = 4'h0;
                    s_d.idx = 9'h000;
                    s_d.st = S_DRAIN;
                end
            end
            S_DRAIN: begin
                if (fq.wr_ready) begin
                    fq.wr_valid = 1'b1;
                    fq.wr_data  = {s_q.idx == 9'h000, s_q.head_eop && last,
                                   head_mem[s_q.idx[7:0]]};
                    s_d.idx = s_q.idx + 9'h001;
                    if (last) begin
                        s_d.idx     = 9'h000;
                        s_d.pkt_cnt = s_q.pkt_cnt + 16'h0001;
                        s_d.st      = s_q.head_eop ? S_FILL : S_PASS;
                    end
                end
            end
            S_PASS: begin
                if (accept) begin
                    fq.wr_valid = 1'b1;
                    fq.wr_data  = {1'b0, in_eop_i, in_data_i};
                    if (in_eop_i) begin
                        s_d.st = S_FILL;
                    end
                end
            end
        endcase
        s_d.in_ready = (s_d.st == S_FILL)
                     || (s_d.st == S_PASS && cnt_next < FIFO_CNT_W'(FIFO_DEPTH));
        if (!s_q.out_valid || out_ready_i) begin
            s_d.out_valid = fq.rd_valid;
            s_d.out_sop   = fq.rd_data[DATA_W+1];
            s_d.out_eop   = fq.rd_data[DATA_W];
            s_d.out_data  = fq.rd_data[DATA_W-1:0];
        end
        if (reg_wr_i) begin
            if (reg_addr_i == REG_PATH_SKEW_DELAY_VALUE) begin
                s_d.path_skew_delay_value = reg_wdata_i;
            end
            if (reg_addr_i == REG_CTRL) begin
                s_d.one_step = reg_wdata_i[CTRL_ONE_STEP_BIT];
            end
        end
        s_d.rdata = 32'h0000_0000;
        if (reg_rd_i) begin
            if (reg_addr_i == REG_PATH_SKEW_DELAY_VALUE) begin
                s_d.rdata = s_q.path_skew_delay_value;
            end
            if (reg_addr_i == REG_CTRL) begin
                s_d.rdata[CTRL_ONE_STEP_BIT] = s_q.one_step;
            end
            if (reg_addr_i == REG_STATUS) begin
                s_d.rdata[STAT_CNT_LSB +: 16] = s_q.pkt_cnt;
                s_d.rdata[STAT_BUSY_BIT] = (s_q.st != S_FILL);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.path_skew_delay_value <= SKEW_RST;
            s_q.one_step <= ONE_STEP_RST;
        end else begin
            s_q <= s_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (we) begin
            head_mem[wa] <= wd;
        end
    end

    assign reg_rdata_o = s_q.rdata;
    assign in_ready_o  = s_q.in_ready;
    assign out_valid_o = s_q.out_valid;
    assign out_data_o  = s_q.out_data;
    assign out_sop_o   = s_q.out_sop;
    assign out_eop_o   = s_q.out_eop;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    a_ts_bytes_placed: assert property (
        $past(s_q.st) == S_TS && s_q.st != S_TS && s_q.fmt == FMT_96
        |-> head_mem[s_q.a_ts] == s_q.ts[95:88]
            && head_mem[8'(s_q.a_ts + 8'h09)] == s_q.ts[23:16]
            && head_mem[s_q.a_cf] == s_q.ts[15:8]
            && head_mem[8'(s_q.a_cf + 8'h01)] == s_q.ts[7:0])
        else $error("stamp bytes misplaced");

    a_cf_window_use: assert property (
        s_q.st == S_CF |-> 8'(wa - s_q.a_cf) <= 8'h07 ##1 s_q.st == S_CF || s_q.k == 4'h0)
        else $error("correction write outside field");

    a_cksum_zeroed: assert property (
        $past(s_q.st) == S_CK && s_q.st == S_DRAIN && s_q.do_zero
        |-> head_mem[s_q.a_ck] == 8'h00 && head_mem[8'(s_q.a_ck + 8'h01)] == 8'h00)
        else $error("checksum not cleared");

    a_cksum_fixed: assert property (
        s_q.st == S_CK && s_q.k == 4'h0 && s_q.do_fix
        |=> ##1 {head_mem[s_q.a_ck], head_mem[8'(s_q.a_ck + 8'h01)]} == s_q.cknew
            && s_q.cknew != 16'h0000)
        else $error("checksum not updated");

    a_one_step_gate: assert property (
        accept && in_sop_i && !s_q.one_step |=> !s_q.do_zero && !s_q.do_fix)
        else $error("checksum request outside one-step");

    a_skew_added: assert property (
        accept && in_sop_i && skew_update_i && !resid_update_i
        |=> s_q.add == {16'h0000, $past(s_q.path_skew_delay_value), 16'h0000})
        else $error("skew delay not added");

    a_fmt_length: assert property (
        $past(s_q.st) == S_TS && s_q.st != S_TS
        |-> $past(s_q.k) == ((s_q.fmt == FMT_64) ? TS_LAST_64 : TS_LAST_96))
        else $error("stamp length wrong for format");

    a_sop_origin: assert property (
        accept && in_sop_i && s_q.st == S_FILL
        |=> head_mem[8'h00] == $past(in_data_i) && s_q.idx == 9'h001)
        else $error("first byte not at offset zero");
endmodule

// ---- dv/pfp_client_model.sv ----
`timescale 1ns/1ps
// transmit client: frames with per-packet controls held on the sop beat
module pfp_client_model (
    input  wire logic         clk_i,
    input  wire logic         in_ready_i,
    output logic              valid_o,
    output logic [7:0]        data_o,
    output logic              sop_o,
    output logic              eop_o,
    output logic [5:0]        ctl_o,
    output logic [63:0]       off_o,
    output logic [191:0]      time_o
);
    initial begin
        valid_o = 1'h0;
        data_o = 8'h00;
        sop_o = 1'h0;
        eop_o = 1'h0;
        ctl_o = 6'h00;
        off_o = 64'h0;
        time_o = 192'h0;
    end
    task automatic send(input logic [7:0] f[$], input logic [5:0] c, input logic [63:0] o,
                        input logic [191:0] t, input logic [31:0] g);
        for (int i = 0; i < f.size(); i++) begin
            valid_o <= 1'h1;
            data_o <= f[i];
            sop_o <= (i == 0);
            eop_o <= (i == f.size() - 1);
            if (i == 0) begin
                ctl_o <= c;
                off_o <= o;
                time_o <= t;
            end
            @(posedge clk_i);
            while (!in_ready_i) @(posedge clk_i);
            if (i == 0) begin
                ctl_o <= ~c;
                off_o <= ~o;
                time_o <= ~t;
            end
            if (g[i % 32]) begin
                valid_o <= 1'h0;
                data_o <= ~f[i];
                sop_o <= 1'h0;
                eop_o <= 1'h0;
                @(posedge clk_i);
            end
        end
        valid_o <= 1'h0;
        data_o <= ~f[f.size() - 1];
        sop_o <= 1'h0;
        eop_o <= 1'h0;
        @(posedge clk_i);
    endtask
endmodule

// ---- dv/ptp_onestep_field_patcher_tb.sv ----
`timescale 1ns/1ps
module ptp_onestep_field_patcher_tb;
    import pfp_pkg::*;
    logic         clk = 1'h0;
    logic         resetn = 1'h0;
    logic         wr = 1'h0;
    logic         rd = 1'h0;
    logic         ordy = 1'h0;
    logic         vld, sop, eop, ack;
    logic [7:0]   addr = 8'h00;
    logic [7:0]   dat;
    logic [31:0]  wdat = 32'h0;
    logic [31:0]  rdat, d, skew;
    logic [31:0]  seed = 32'h0001_298F;
    logic [5:0]   ctl;
    logic [63:0]  off;
    logic [191:0] tim;
    logic [7:0]   odat;
    logic         ovld, osop, oeop;
    logic [9:0]   rx[$];
    int           n_errors = 0;
    int           checked = 0;
    int           cyc = 0;
    int           npk = 0;
    always #25 clk = ~clk;
    pfp_client_model u_pfp_client_model (.clk_i(clk), .in_ready_i(ack), .valid_o(vld),
        .data_o(dat), .sop_o(sop), .eop_o(eop), .ctl_o(ctl), .off_o(off), .time_o(tim));
    pfp_field_patcher u_pfp_field_patcher (.clk_i(clk), .resetn_i(resetn), .reg_addr_i(addr),
        .reg_wdata_i(wdat), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
        .in_valid_i(vld), .in_ready_o(ack), .in_data_i(dat), .in_sop_i(sop), .in_eop_i(eop),
        .ts_insert_i(ctl[5]), .ts_format_i(ctl[4]), .resid_update_i(ctl[3]),
        .skew_update_i(ctl[2]), .zero_cksum_i(ctl[1]), .fix_cksum_i(ctl[0]),
        .off_ts_i(off[63:48]), .off_cf_i(off[47:32]), .off_zero_i(off[31:16]),
        .off_fix_i(off[15:0]), .tod_i(tim[191:96]), .ingress_i(tim[95:0]),
        .out_valid_o(ovld), .out_ready_i(ordy), .out_data_o(odat), .out_sop_o(osop),
        .out_eop_o(oeop));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] oa(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = a + b;
        return s[15:0] + s[16];
    endfunction
    function automatic logic [15:0] osum(input logic [7:0] f[$], input int p);
        logic [15:0] s;
        s = 16'h0000;
        for (int i = p; i < f.size(); i += 2) begin
            s = oa(s, {f[i], (i + 1 < f.size()) ? f[i + 1] : 8'h00});
        end
        return s;
    endfunction
    task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("checked %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] v);
        addr <= a;
        wdat <= v;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
        @(posedge clk);
    endtask
    task automatic rreg(input logic [7:0] a, output logic [31:0] v);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        @(posedge clk);
        v = rdat;
    endtask
    // behavioural reference: patch a copy of the frame, then compare every output byte
    task automatic pkt(input logic [5:0] c, input int n, input logic [63:0] o, input logic os);
        logic [7:0]   f[$];
        logic [7:0]   e[$];
        logic [7:0]   g[$];
        logic [191:0] t;
        logic [63:0]  cf, rs;
        logic [15:0]  cs;
        int           ot, oc, oz, ox;
        ot = o[55:48];
        oc = o[39:32];
        oz = o[23:16];
        ox = o[7:0];
        wreg(REG_CTRL, {31'h0000_0000, os});
        for (int i = 0; i < n; i++) begin
            seed = lfsr(seed);
            f.push_back(seed[7:0]);
        end
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            t[32*i +: 32] = seed;
        end
        t[143:112] = t[143:112] % NS_PER_SEC;
        t[47:16] = t[47:16] % NS_PER_SEC;
        rx.delete();
        seed = lfsr(seed);
        u_pfp_client_model.send(f, c, o, t, seed & 32'h0842_1084);
        for (int k = 0; k < 4000 && rx.size() < n; k++) @(posedge clk);
        e = f;
        for (int i = 0; c[5] && i < (c[4] ? 8 : 10); i++) begin
            e[ot + i] = c[4] ? t[175 - 8 * i -: 8] : t[191 - 8 * i -: 8];
        end
        if (c[5] && !c[4]) begin
            e[oc] = t[111:104];
            e[oc + 1] = t[103:96];
        end
        if (c[3] || c[2]) begin
            cf = 64'h0;
            for (int i = 0; i < 8; i++) cf = {cf[55:0], e[oc + i]};
            rs = t[143:112] + ((t[143:112] < t[47:16]) ? NS_PER_SEC : 32'h0) - t[47:16];
            cf += ((c[3] ? rs : 64'h0) + (c[2] ? skew : 32'h0)) << 16;
            for (int i = 0; i < 8; i++) e[oc + i] = cf[63 - 8 * i -: 8];
        end
        if (os && c[1]) begin
            e[oz] = 8'h00;
            e[oz + 1] = 8'h00;
        end else if (os && c[0]) begin
            cs = {f[ox], f[ox + 1]};
            g = f;
            g[ox] = 8'h00;
            g[ox + 1] = 8'h00;
            e[ox] = 8'h00;
            e[ox + 1] = 8'h00;
            cs = ~oa(oa(~cs, osum(e, ox % 2)), ~osum(g, ox % 2));
            if (cs == 16'h0000) cs = 16'hFFFF;
            e[ox] = cs[15:8];
            e[ox + 1] = cs[7:0];
        end
        check("frame_len", rx.size(), n);
        for (int i = 0; i < n && i < rx.size(); i++) begin
            check("out_byte", rx[i], {i == 0, i == n - 1, e[i]});
        end
        npk++;
        rreg(REG_STATUS, d);
        check("pkt_count", d[31:16], npk);
        check("busy", d[0], 1'h0);
        $display("packet test done ctl %h len %0d", c, n);
    endtask
    always @(posedge clk) begin
        ordy <= (cyc % 7) != 3;
        if (ovld && ordy) rx.push_back({osop, oeop, odat});
        cyc++;
        if (cyc == 60000) begin
            n_errors++;
            test_done();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'h1;
        repeat (4) @(posedge clk);
        rreg(REG_PATH_SKEW_DELAY_VALUE, d);
        check("skew_rst", d, SKEW_RST);
        rreg(REG_CTRL, d);
        check("ctrl_rst", d, {31'h0000_0000, ONE_STEP_RST});
        skew = lfsr(seed);
        wreg(REG_PATH_SKEW_DELAY_VALUE, skew);
        rreg(REG_PATH_SKEW_DELAY_VALUE, d);
        check("skew_reg", d, skew);
        rreg(8'h0C, d);
        check("unmapped", d, 32'h0);
        $display("register test done");
        pkt(6'h20, 64, 64'h0014_0028_0000_0000, 1'h1);
        pkt(6'h30, 64, 64'h000A_0000_0000_0000, 1'h0);
        pkt(6'h08, 64, 64'h0000_0008_0000_0000, 1'h1);
        pkt(6'h0C, 300, 64'h0000_0030_0000_0000, 1'h1);
        pkt(6'h04, 64, 64'h0000_0018_0000_0000, 1'h0);
        pkt(6'h02, 64, 64'h0000_0000_001E_0000, 1'h1);
        pkt(6'h02, 64, 64'h0000_0000_001E_0000, 1'h0);
        pkt(6'h21, 80, 64'h0014_0028_0000_0032, 1'h1);
        pkt(6'h0D, 90, 64'h0000_0010_0000_0033, 1'h1);
        pkt(6'h21, 80, 64'h0014_0028_0000_0032, 1'h0);
        test_done();
    end
endmodule
